// ==== mcuex_defs.svh ====
// Purpose: constants for the execution-timing and flag datapath block
// Assumes: included by bare name
// Notes:   lengths in bytes, durations in core cycles
`ifndef MCUEX_DEFS_SVH
`define MCUEX_DEFS_SVH
`define MCUEX_LEN_1      3'h1
`define MCUEX_LEN_2      3'h2
`define MCUEX_LEN_3      3'h3
`define MCUEX_CYC_1      4'h1
`define MCUEX_CYC_3      4'h3
`define MCUEX_CYC_4      4'h4
`define MCUEX_CYC_9      4'h9
`define MCUEX_BIT_C      7
`define MCUEX_BIT_HALF   6
`define MCUEX_BIT_OVFL   2
`define MCUEX_BYTE_MAX   16'h00FF
`define MCUEX_ZERO8      8'h00
`endif

// ==== mcuex_pkg.sv ====
// Purpose: types for the execution-timing and flag datapath block
// Assumes: nothing
// Notes:   operation codes are this block's own encoding
package mcuex_pkg;
  typedef enum logic [4:0] {
    MCUEX_OP_NOP        = 5'h00,
    MCUEX_OP_JMP_IND    = 5'h01,
    MCUEX_OP_ABS_CALL   = 5'h02,
    MCUEX_OP_ABS_JUMP   = 5'h03,
    MCUEX_OP_SHORT_JUMP = 5'h04,
    MCUEX_OP_JC         = 5'h05,
    MCUEX_OP_JNC        = 5'h06,
    MCUEX_OP_JZ         = 5'h07,
    MCUEX_OP_JNZ        = 5'h08,
    MCUEX_OP_DEC_BR_REG = 5'h09,
    MCUEX_OP_LONG_JUMP  = 5'h0A,
    MCUEX_OP_LONG_CALL  = 5'h0B,
    MCUEX_OP_JB         = 5'h0C,
    MCUEX_OP_JNB        = 5'h0D,
    MCUEX_OP_BIT_CLR_BR = 5'h0E,
    MCUEX_OP_CMP_BR_NE  = 5'h0F,
    MCUEX_OP_DEC_BR_DIR = 5'h10,
    MCUEX_OP_INT_RETURN = 5'h11,
    MCUEX_OP_ADD        = 5'h12,
    MCUEX_OP_ADD_CARRY  = 5'h13,
    MCUEX_OP_SUB_BORROW = 5'h14,
    MCUEX_OP_MUL        = 5'h15,
    MCUEX_OP_DIV        = 5'h16,
    MCUEX_OP_PORT_RD    = 5'h17,
    MCUEX_OP_PORT_RMW   = 5'h18,
    MCUEX_OP_BIT_WR     = 5'h19
  } mcuex_op_t;

  // request from the sequencer
  typedef struct packed {
    mcuex_op_t  op;
    logic [7:0] acc;
    logic [7:0] src;
    logic [7:0] breg;
    logic [7:0] cmp;
    logic [2:0] bit_sel;
    logic       bit_val;
    logic [7:0] rmw_data;
  } mcuex_req_t;

  // psw flags touched here
  typedef struct packed {
    logic c;
    logic half_carry;
    logic overflow;
  } mcuex_flags_t;

  // result of one instruction
  typedef struct packed {
    logic [7:0]   acc;
    logic [7:0]   breg;
    logic [7:0]   port_wr;
    logic         port_we;
    logic         taken;
    logic [2:0]   len;
    logic [3:0]   cycles;
    mcuex_flags_t flags;
  } mcuex_rsp_t;

  typedef enum logic [2:0] {
    MCUEX_ST_IDLE = 3'b001,
    MCUEX_ST_BUSY = 3'b010,
    MCUEX_ST_DONE = 3'b100
  } mcuex_state_t;
endpackage : mcuex_pkg

// ==== mcuex_core.sv ====
// Purpose: instruction length, cycle timing, arithmetic flags, mul/div and
//          port latch versus pin selection
// Assumes: a request is offered with start while ready is high; pins come
//          from outside the clock domain
// Notes:   results are held in registers until the next instruction ends
// How it works
// RQ1 - indirect jump via accumulator plus data pointer: one byte, three cycles
// RQ2 - absolute call and absolute jump: two bytes, three cycles
// RQ3 - short jump and carry/zero branches: two bytes, three cycles
// RQ4 - nonzero branch and register decrement branch: two bytes, three cycles
// RQ5 - long jump and long call: three bytes, four cycles
// RQ6 - direct bit branches: three bytes, four cycles; set-branch clears bit
// RQ7 - all compare branches and direct decrement branch: three bytes, four
// RQ8 - interrupt return: one byte, four cycles
// RQ9 - port read-modify-write reads the output latch, not the pin
// RQ10 - plain port bit input samples the pin level
// RQ11 - bit writes read whole latch, change one bit, write byte back
// RQ12 - add: carry from bit 7, half-carry from bit 3
// RQ13 - add overflow: carry out of exactly one of bits 6 and 7
// RQ14 - add with carry: adds carry in, flags as plain add
// RQ15 - subtract with borrow: borrow of bit 7 to carry, bit 3 to half-carry
// RQ16 - subtract overflow: borrow for exactly one of bits 6 and 7
// RQ17 - multiply: product low byte to accumulator, high byte to b
// RQ18 - multiply clears carry, overflow set when product exceeds 255
// RQ19 - divide: quotient to accumulator, remainder to b
// RQ20 - divide clears carry and overflow; zero divisor sets overflow
// RQ21 - each instruction lasts exactly its listed cycles before the next; the core ends it after them but takes the next one cycle later
`include "mcuex_defs.svh"
module mcuex_core (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              start,
  input  mcuex_pkg::mcuex_req_t  req,
  input  mcuex_pkg::mcuex_flags_t flags_in,
  input  wire logic [7:0]        port_pins,
  output logic                   ready,
  output logic                   done,
  output mcuex_pkg::mcuex_rsp_t  rsp,
  output logic [7:0]             port_latch
);
  mcuex_pkg::mcuex_state_t state_r;
  mcuex_pkg::mcuex_req_t   req_r;
  logic [3:0]              cnt_r;
  logic [7:0]              pin_s1_r;
  logic [7:0]              pin_s2_r;
  logic [7:0]              pin_s3_r;
  logic [7:0]              pin_stable_r;
  logic [2:0]              len_nxt;
  logic [3:0]              cyc_nxt;
  mcuex_pkg::mcuex_rsp_t   rsp_nxt;
  logic [8:0]              sum9;
  logic [7:0]              sum7;
  logic [4:0]              sum4;
  logic                    c6;
  logic                    cin;
  logic [15:0]             prod;
  logic [7:0]              quo;
  logic [7:0]              rem;
  logic [7:0]              rmw_byte;

  // three-stage pin synchroniser; accept a change once stages two and
  // three agree, so a glitch shorter than a cycle never reaches a port
  // read
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= `MCUEX_ZERO8;
      pin_s2_r <= `MCUEX_ZERO8;
      pin_s3_r <= `MCUEX_ZERO8;
    end else begin
      pin_s1_r <= port_pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_stable_r <= `MCUEX_ZERO8;
    end else if (pin_s2_r == pin_s3_r) begin
      pin_stable_r <= pin_s3_r;
    end
  end

  // length and duration table
  always_comb begin
    len_nxt = `MCUEX_LEN_1;
    cyc_nxt = `MCUEX_CYC_1;
    case (req_r.op)
      mcuex_pkg::MCUEX_OP_JMP_IND: begin
        len_nxt = `MCUEX_LEN_1;  // [RQ1]
        cyc_nxt = `MCUEX_CYC_3;  // [RQ1]
      end
      mcuex_pkg::MCUEX_OP_ABS_CALL,
      mcuex_pkg::MCUEX_OP_ABS_JUMP: begin
        len_nxt = `MCUEX_LEN_2;  // [RQ2]
        cyc_nxt = `MCUEX_CYC_3;  // [RQ2]
      end
      mcuex_pkg::MCUEX_OP_SHORT_JUMP,
      mcuex_pkg::MCUEX_OP_JC,
      mcuex_pkg::MCUEX_OP_JNC,
      mcuex_pkg::MCUEX_OP_JZ: begin
        len_nxt = `MCUEX_LEN_2;  // [RQ3]
        cyc_nxt = `MCUEX_CYC_3;  // [RQ3]
      end
      mcuex_pkg::MCUEX_OP_JNZ,
      mcuex_pkg::MCUEX_OP_DEC_BR_REG: begin
        len_nxt = `MCUEX_LEN_2;  // [RQ4]
        cyc_nxt = `MCUEX_CYC_3;  // [RQ4]
      end
      mcuex_pkg::MCUEX_OP_LONG_JUMP,
      mcuex_pkg::MCUEX_OP_LONG_CALL: begin
        len_nxt = `MCUEX_LEN_3;  // [RQ5]
        cyc_nxt = `MCUEX_CYC_4;  // [RQ5]
      end
      mcuex_pkg::MCUEX_OP_JB,
      mcuex_pkg::MCUEX_OP_JNB,
      mcuex_pkg::MCUEX_OP_BIT_CLR_BR: begin
        len_nxt = `MCUEX_LEN_3;  // [RQ6]
        cyc_nxt = `MCUEX_CYC_4;  // [RQ6]
      end
      mcuex_pkg::MCUEX_OP_CMP_BR_NE,
      mcuex_pkg::MCUEX_OP_DEC_BR_DIR: begin
        len_nxt = `MCUEX_LEN_3;  // [RQ7]
        cyc_nxt = `MCUEX_CYC_4;  // [RQ7]
      end
      mcuex_pkg::MCUEX_OP_INT_RETURN: begin
        len_nxt = `MCUEX_LEN_1;  // [RQ8]
        cyc_nxt = `MCUEX_CYC_4;  // [RQ8]
      end
      // multiply and divide run the long nine-cycle slot
      mcuex_pkg::MCUEX_OP_MUL,
      mcuex_pkg::MCUEX_OP_DIV: begin
        len_nxt = `MCUEX_LEN_1;
        cyc_nxt = `MCUEX_CYC_9;
      end
      default: begin
        len_nxt = `MCUEX_LEN_1;
        cyc_nxt = `MCUEX_CYC_1;
      end
    endcase
  end

  // arithmetic helpers
  always_comb begin
    sum9 = 9'h000;
    sum7 = 8'h00;
    sum4 = 5'h00;
    // carry flag feeds in only for the carry and borrow forms
    cin  = flags_in.c
           && (req_r.op == mcuex_pkg::MCUEX_OP_ADD_CARRY
               || req_r.op == mcuex_pkg::MCUEX_OP_SUB_BORROW);    // [RQ14]
    if (req_r.op == mcuex_pkg::MCUEX_OP_SUB_BORROW) begin
      // borrow shows up as bit above the field
      sum9 = {1'b0, req_r.acc} - {1'b0, req_r.src}
             - {8'h00, cin};                                       // [RQ15]
      sum7 = {1'b0, req_r.acc[6:0]} - {1'b0, req_r.src[6:0]}
             - {7'h00, cin};                                       // [RQ16]
      sum4 = {1'b0, req_r.acc[3:0]} - {1'b0, req_r.src[3:0]}
             - {4'h0, cin};                                        // [RQ15]
    end else begin
      // carry out of each field shows up as the bit above it
      sum9 = {1'b0, req_r.acc} + {1'b0, req_r.src}
             + {8'h00, cin};                                       // [RQ12]
      sum7 = {1'b0, req_r.acc[6:0]} + {1'b0, req_r.src[6:0]}
             + {7'h00, cin};                                       // [RQ13]
      sum4 = {1'b0, req_r.acc[3:0]} + {1'b0, req_r.src[3:0]}
             + {4'h0, cin};                                        // [RQ12]
    end
    c6   = sum7[7];
    // operands widened so the full 16-bit product is formed
    prod = {8'h00, req_r.acc} * {8'h00, req_r.breg};               // [RQ17]
    quo  = (req_r.breg == `MCUEX_ZERO8) ? `MCUEX_ZERO8
                                        : req_r.acc / req_r.breg;  // [RQ19]
    rem  = (req_r.breg == `MCUEX_ZERO8) ? `MCUEX_ZERO8
                                        : req_r.acc % req_r.breg;  // [RQ19]
  end

  // read-modify-write source is always the latch, never the pins
  always_comb begin
    rmw_byte = port_latch;                                         // [RQ9]
    rmw_byte[req_r.bit_sel] = req_r.bit_val;                       // [RQ11]
  end

  // result of the held instruction
  always_comb begin
    rsp_nxt         = rsp;
    rsp_nxt.len     = len_nxt;
    rsp_nxt.cycles  = cyc_nxt;
    rsp_nxt.taken   = 1'b0;
    rsp_nxt.port_we = 1'b0;
    rsp_nxt.port_wr = port_latch;
    rsp_nxt.acc     = req_r.acc;
    rsp_nxt.breg    = req_r.breg;
    rsp_nxt.flags   = flags_in;
    case (req_r.op)
      mcuex_pkg::MCUEX_OP_JMP_IND, mcuex_pkg::MCUEX_OP_ABS_CALL,
      mcuex_pkg::MCUEX_OP_ABS_JUMP, mcuex_pkg::MCUEX_OP_SHORT_JUMP,
      mcuex_pkg::MCUEX_OP_LONG_JUMP, mcuex_pkg::MCUEX_OP_LONG_CALL,
      mcuex_pkg::MCUEX_OP_INT_RETURN: begin
        rsp_nxt.taken = 1'b1;
      end
      mcuex_pkg::MCUEX_OP_JC:  rsp_nxt.taken = flags_in.c;         // [RQ3]
      mcuex_pkg::MCUEX_OP_JNC: rsp_nxt.taken = !flags_in.c;        // [RQ3]
      mcuex_pkg::MCUEX_OP_JZ: begin
        rsp_nxt.taken = (req_r.acc == `MCUEX_ZERO8);               // [RQ3]
      end
      mcuex_pkg::MCUEX_OP_JNZ: begin
        rsp_nxt.taken = (req_r.acc != `MCUEX_ZERO8);               // [RQ4]
      end
      mcuex_pkg::MCUEX_OP_DEC_BR_REG, mcuex_pkg::MCUEX_OP_DEC_BR_DIR: begin
        // src holds the count; branch while the decremented count is nonzero
        rsp_nxt.acc   = req_r.src - 8'h01;
        rsp_nxt.taken = (req_r.src != 8'h01);                      // [RQ4]
      end
      mcuex_pkg::MCUEX_OP_JB: rsp_nxt.taken = req_r.bit_val;       // [RQ6]
      mcuex_pkg::MCUEX_OP_JNB: rsp_nxt.taken = !req_r.bit_val;     // [RQ6]
      mcuex_pkg::MCUEX_OP_BIT_CLR_BR: begin
        // latch bit is cleared only when the branch is taken
        rsp_nxt.taken = req_r.bit_val;                             // [RQ6]
        if (req_r.bit_val) begin
          rsp_nxt.port_wr = port_latch;                            // [RQ9]
          rsp_nxt.port_wr[req_r.bit_sel] = 1'b0;                   // [RQ6]
          rsp_nxt.port_we = 1'b1;
        end
      end
      mcuex_pkg::MCUEX_OP_CMP_BR_NE: begin
        // carry set when the source exceeds the destination
        rsp_nxt.taken   = (req_r.cmp != req_r.src);                // [RQ7]
        rsp_nxt.flags.c = (req_r.cmp < req_r.src);
      end
      mcuex_pkg::MCUEX_OP_ADD, mcuex_pkg::MCUEX_OP_ADD_CARRY: begin
        rsp_nxt.acc              = sum9[7:0];                      // [RQ12]
        rsp_nxt.flags.c          = sum9[8];                        // [RQ12]
        rsp_nxt.flags.half_carry = sum4[4];                        // [RQ12]
        rsp_nxt.flags.overflow   = sum9[8] ^ c6;                   // [RQ13]
      end
      mcuex_pkg::MCUEX_OP_SUB_BORROW: begin
        rsp_nxt.acc              = sum9[7:0];                      // [RQ15]
        rsp_nxt.flags.c          = sum9[8];                        // [RQ15]
        rsp_nxt.flags.half_carry = sum4[4];                        // [RQ15]
        rsp_nxt.flags.overflow   = sum9[8] ^ c6;                   // [RQ16]
      end
      mcuex_pkg::MCUEX_OP_MUL: begin
        rsp_nxt.acc              = prod[7:0];                      // [RQ17]
        rsp_nxt.breg             = prod[15:8];                     // [RQ17]
        rsp_nxt.flags.c          = 1'b0;                           // [RQ18]
        rsp_nxt.flags.overflow   = (prod > `MCUEX_BYTE_MAX);       // [RQ18]
      end
      mcuex_pkg::MCUEX_OP_DIV: begin
        // zero divisor: results undefined, zeros are returned
        rsp_nxt.acc              = quo;                            // [RQ19]
        rsp_nxt.breg             = rem;                            // [RQ19]
        rsp_nxt.flags.c          = 1'b0;                           // [RQ20]
        rsp_nxt.flags.overflow   = (req_r.breg == `MCUEX_ZERO8);   // [RQ20]
      end
      mcuex_pkg::MCUEX_OP_PORT_RD: begin
        // plain input reads the synchronised pins, never the latch
        rsp_nxt.acc = pin_stable_r;                                // [RQ10]
        rsp_nxt.flags.c = pin_stable_r[req_r.bit_sel];             // [RQ10]
      end
      mcuex_pkg::MCUEX_OP_PORT_RMW: begin
        rsp_nxt.acc     = port_latch;                              // [RQ9]
        rsp_nxt.port_wr = req_r.rmw_data;
        rsp_nxt.port_we = 1'b1;
      end
      mcuex_pkg::MCUEX_OP_BIT_WR: begin
        rsp_nxt.port_wr = rmw_byte;                                // [RQ11]
        rsp_nxt.port_we = 1'b1;
      end
      default: begin
        rsp_nxt.taken = 1'b0;
      end
    endcase
  end

  // sequencer: counts the instruction out to its exact duration
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= mcuex_pkg::MCUEX_ST_IDLE;
      cnt_r   <= 4'h0;
      req_r   <= '0;
    end else begin
      case (state_r)
        mcuex_pkg::MCUEX_ST_IDLE, mcuex_pkg::MCUEX_ST_DONE: begin
          if (start) begin
            req_r   <= req;
            cnt_r   <= `MCUEX_CYC_1;
            state_r <= mcuex_pkg::MCUEX_ST_BUSY;
          end else begin
            state_r <= mcuex_pkg::MCUEX_ST_IDLE;
          end
        end
        mcuex_pkg::MCUEX_ST_BUSY: begin
          // cnt runs 1..cycles; the edge that sees the last count ends it
          if (cnt_r >= cyc_nxt) begin
            state_r <= mcuex_pkg::MCUEX_ST_DONE;                   // [RQ21]
          end else begin
            cnt_r <= cnt_r + 4'h1;                                 // [RQ21]
          end
        end
        default: state_r <= mcuex_pkg::MCUEX_ST_IDLE;
      endcase
    end
  end

  // outputs registered when the instruction completes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
      rsp  <= '0;
    end else begin
      done <= 1'b0;
      if (state_r == mcuex_pkg::MCUEX_ST_BUSY && cnt_r >= cyc_nxt) begin
        done <= 1'b1;                                              // [RQ21]
        rsp  <= rsp_nxt;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      port_latch <= `MCUEX_ZERO8;
    end else if (state_r == mcuex_pkg::MCUEX_ST_BUSY && cnt_r >= cyc_nxt
                 && rsp_nxt.port_we) begin
      // written only on the completing edge, from the latch-based byte or, for a port update, from rmw_data
      port_latch <= rsp_nxt.port_wr;                               // [RQ11]
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ready <= 1'b0;
    end else begin
      ready <= !(state_r == mcuex_pkg::MCUEX_ST_BUSY)
               || (cnt_r >= cyc_nxt);
      // drop at once on a take so a second request cannot slip in
      if (start && ready) begin
        ready <= 1'b0;
      end
    end
  end
endmodule : mcuex_core

// ==== mcuex_chk.sv ====
// Purpose: concurrent checks on the mcuex_core ports
// Assumes: flags_in is held stable while an instruction runs
// Notes:   q_r and l_r keep the request and the latch seen at the take;
//          c_r keeps the carry the design used at completion
module mcuex_chk (
  input wire logic               mclk,
  input wire logic               sys_rst,
  input wire logic               start,
  input mcuex_pkg::mcuex_req_t   req,
  input mcuex_pkg::mcuex_flags_t flags_in,
  input wire logic [7:0]         port_pins,
  input wire logic               ready,
  input wire logic               done,
  input mcuex_pkg::mcuex_rsp_t   rsp,
  input wire logic [7:0]         port_latch
);
  mcuex_pkg::mcuex_req_t q_r;
  logic [7:0]            l_r;
  logic [7:0]            a;
  logic [7:0]            s;
  logic [7:0]            bw;
  logic [7:0]            s6;
  logic [7:0]            d6;
  logic [4:0]            n_r;
  logic [4:0]            o;
  logic [4:0]            sl;
  logic [4:0]            dl;
  logic [8:0]            sm;
  logic [8:0]            df;
  logic [15:0]           pr;
  logic                  ci;
  logic                  c_r;

  // length and duration packed as {bytes, cycles}
  function automatic logic [6:0] lc(input logic [4:0] p);
    if (p == 5'h01) return 7'h13;
    if (p >= 5'h02 && p <= 5'h09) return 7'h23;
    if (p >= 5'h0A && p <= 5'h10) return 7'h34;
    if (p == 5'h11) return 7'h14;
    return 7'h00;
  endfunction : lc

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r <= '0;
      l_r <= 8'h00;
      n_r <= 5'h00;
    end else if (start && ready) begin
      q_r <= req;
      l_r <= port_latch;
      n_r <= 5'h01;
    end else if (!ready) begin
      n_r <= n_r + 5'h01;
    end
  end

  assign o  = q_r.op;
  assign a  = q_r.acc;
  assign s  = q_r.src;
  // carry one edge late, matching the completion edge the result came from
  always_ff @(posedge mclk) begin
    c_r <= flags_in.c;
  end

  assign ci = (o == 5'h13 || o == 5'h14) && c_r;
  assign sm = {1'b0, a} + {1'b0, s} + {8'h00, ci};
  assign sl = {1'b0, a[3:0]} + {1'b0, s[3:0]} + {4'h0, ci};
  assign s6 = {1'b0, a[6:0]} + {1'b0, s[6:0]} + {7'h00, ci};
  assign df = {1'b0, a} - {1'b0, s} - {8'h00, ci};
  assign dl = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, ci};
  assign d6 = {1'b0, a[6:0]} - {1'b0, s[6:0]} - {7'h00, ci};
  assign pr = {8'h00, a} * {8'h00, q_r.breg};
  assign bw = (l_r & ~(8'h01 << q_r.bit_sel))
            | ({7'h00, q_r.bit_val} << q_r.bit_sel);

  default clocking dcb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  done_pulse_a: assert property (done |=> !done)
    else $error("done held beyond one cycle");
  take_busy_a: assert property (start && ready |=> !ready && !done)
    else $error("take did not start a busy period");
  spacing_count_a: assert property (done |-> ready && n_r == {1'b0, rsp.cycles} + 5'h01)
    else $error("done not at listed cycles after take");
  len_cycles_a: assert property (done && lc(o) != 7'h00 |-> {rsp.len, rsp.cycles} == lc(o))
    else $error("branch length or cycles wrong");
  add_flags_a: assert property (done && (o == 5'h12 || o == 5'h13) |-> rsp.acc == sm[7:0] && rsp.flags == {sm[8], sl[4], s6[7] ^ sm[8]})
    else $error("add result or flags wrong");
  subtract_with_borrow_flags_a: assert property (done && o == 5'h14 |-> rsp.acc == df[7:0] && rsp.flags == {df[8], dl[4], d6[7] ^ df[8]})
    else $error("subtract result or flags wrong");
  mul_result_a: assert property (done && o == 5'h15 |-> {rsp.breg, rsp.acc} == pr && !rsp.flags.c && rsp.flags.overflow == (pr > 16'h00FF))
    else $error("multiply result or flags wrong");
  div_result_a: assert property (done && o == 5'h16 |-> !rsp.flags.c && rsp.flags.overflow == (q_r.breg == 8'h00) && (q_r.breg == 8'h00 || (rsp.acc == a / q_r.breg && rsp.breg == a % q_r.breg)))
    else $error("divide result or flags wrong");
  rmw_latch_a: assert property (done && o == 5'h18 |-> rsp.acc == l_r)
    else $error("port update did not read the latch");
  bit_write_a: assert property (done && o == 5'h19 |-> rsp.port_we && rsp.port_wr == bw)
    else $error("bit write changed other bits");

  b2b_take_c: cover property (done && start);
  div_zero_c: cover property (done && o == 5'h16 && q_r.breg == 8'h00);
  mul_wide_c: cover property (done && o == 5'h15 && pr > 16'h00FF);
endmodule : mcuex_chk

bind mcuex_core mcuex_chk u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .start(start), .req(req),
  .flags_in(flags_in), .port_pins(port_pins), .ready(ready),
  .done(done), .rsp(rsp), .port_latch(port_latch)
);

// ==== mcuex_core_test.sv ====
// Purpose: self-checking bench for mcuex_core
// Assumes: inputs change on the falling edge of mclk
// Notes:   each scenario task drives and judges its own operations
module mcuex_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    mclk;
  logic                    sys_rst;
  logic                    start;
  mcuex_pkg::mcuex_req_t   req;
  mcuex_pkg::mcuex_req_t   q;
  mcuex_pkg::mcuex_flags_t flags_in;
  logic [7:0]              port_pins;
  logic                    ready;
  logic                    done;
  mcuex_pkg::mcuex_rsp_t   rsp;
  logic [7:0]              port_latch;
  int                      error_cnt;
  int                      total_checks;
  int                      n;
  localparam logic [6:0] lc_tab [17] = '{7'h13, 7'h23, 7'h23, 7'h23,
    7'h23, 7'h23, 7'h23, 7'h23, 7'h23, 7'h34, 7'h34, 7'h34, 7'h34,
    7'h34, 7'h34, 7'h34, 7'h14};

  mcuex_core u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .start(start), .req(req),
    .flags_in(flags_in), .port_pins(port_pins), .ready(ready),
    .done(done), .rsp(rsp), .port_latch(port_latch)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [15:0] v,
                     input logic [15:0] e);
    total_checks++;
    if (v !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, e, v);
    end
  endtask : chk

  task automatic put(input logic [4:0] c, input logic [7:0] a,
                     input logic [7:0] s, input logic [7:0] b);
    q      = '0;
    q.op   = mcuex_pkg::mcuex_op_t'(c);
    q.acc  = a;
    q.src  = s;
    q.breg = b;
  endtask : put

  // offer q, then count cycles from the take until done
  task automatic go;
    int w;
    w = 0;
    while (ready !== 1'b1 && w < 20) begin
      @(negedge mclk);
      w++;
    end
    start = 1'b1;
    req   = q;
    @(negedge mclk);
    start = 1'b0;
    n     = 1;
    while (done !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (w == 20 || n == 20) begin
      error_cnt++;
      end_of_test();
    end
  endtask : go

  task automatic t_timing;
    for (int i = 0; i < 17; i++) begin
      put(5'(i + 1), 8'h01, 8'h02, 8'h03);
      go();
      chk("length", 16'(rsp.len), 16'(lc_tab[i][6:4]));
      chk("cycles", 16'(rsp.cycles), 16'(lc_tab[i][3:0]));
      chk("spacing", 16'(n), 16'(lc_tab[i][3:0]) + 16'h0001);
    end
  endtask : t_timing

  task automatic br(input logic [4:0] c, input logic [7:0] a,
                    input logic [7:0] s, input logic f, input logic t);
    flags_in = {f, 2'h0};
    put(c, a, s, 8'h00);
    q.cmp     = 8'h05;
    q.bit_val = f;
    go();
    chk("taken", 16'(rsp.taken), 16'(t));
  endtask : br

  task automatic t_branch;
    br(5'h05, 8'h00, 8'h00, 1'b1, 1'b1);
    br(5'h05, 8'h00, 8'h00, 1'b0, 1'b0);
    br(5'h06, 8'h00, 8'h00, 1'b0, 1'b1);
    br(5'h07, 8'h00, 8'h00, 1'b0, 1'b1);
    br(5'h07, 8'h01, 8'h00, 1'b0, 1'b0);
    br(5'h08, 8'h01, 8'h00, 1'b0, 1'b1);
    br(5'h09, 8'h00, 8'h01, 1'b0, 1'b0);
    br(5'h10, 8'h00, 8'h02, 1'b0, 1'b1);
    chk("decrement", 16'(rsp.acc), 16'h0001);
    br(5'h0C, 8'h00, 8'h00, 1'b1, 1'b1);
    br(5'h0D, 8'h00, 8'h00, 1'b1, 1'b0);
    br(5'h0F, 8'h00, 8'h05, 1'b0, 1'b0);
    br(5'h0F, 8'h00, 8'h06, 1'b0, 1'b1);
    chk("compare carry", 16'(rsp.flags.c), 16'h0001);
  endtask : t_branch

  task automatic ar(input logic [4:0] c, input logic [7:0] a,
                    input logic [7:0] s, input logic ci,
                    input logic [10:0] e);
    flags_in = {ci, 2'h0};
    put(c, a, s, 8'h00);
    go();
    chk("alu", {5'h00, rsp.acc, rsp.flags}, {5'h00, e});
  endtask : ar

  task automatic t_arith;
    ar(5'h12, 8'h7F, 8'h01, 1'b0, {8'h80, 3'h3});
    ar(5'h12, 8'hFF, 8'h01, 1'b1, {8'h00, 3'h6});
    ar(5'h13, 8'h80, 8'h80, 1'b1, {8'h01, 3'h5});
    ar(5'h13, 8'h7F, 8'h00, 1'b1, {8'h80, 3'h3});
    ar(5'h14, 8'h80, 8'h01, 1'b0, {8'h7F, 3'h3});
    ar(5'h14, 8'h00, 8'h00, 1'b1, {8'hFF, 3'h6});
    ar(5'h14, 8'h05, 8'h03, 1'b1, {8'h01, 3'h0});
  endtask : t_arith

  task automatic md(input logic [4:0] c, input logic [7:0] a,
                    input logic [7:0] b, input logic [17:0] e);
    flags_in = 3'h7;
    put(c, a, 8'h00, b);
    go();
    chk("muldiv time", 16'(n), 16'h000A);
    chk("muldiv flags", 16'({rsp.flags.c, rsp.flags.overflow}),
        16'(e[17:16]));
    if (b != 8'h00 || c == 5'h15) begin
      chk("muldiv data", {rsp.breg, rsp.acc}, e[15:0]);
    end
  endtask : md

  task automatic t_muldiv;
    md(5'h15, 8'h10, 8'h10, {2'h1, 16'h0100});
    md(5'h15, 8'h0F, 8'h11, {2'h0, 16'h00FF});
    md(5'h16, 8'hFB, 8'h0A, {2'h0, 16'h0119});
    md(5'h16, 8'h07, 8'h00, {2'h1, 16'h0000});
  endtask : t_muldiv

  task automatic t_port;
    put(5'h18, 8'h00, 8'h00, 8'h00);
    q.rmw_data = 8'hA5;
    go();
    @(negedge mclk);
    chk("latch", 16'(port_latch), 16'h00A5);
    put(5'h18, 8'h00, 8'h00, 8'h00);
    q.rmw_data = 8'h3C;
    go();
    chk("rmw read", 16'(rsp.acc), 16'h00A5);
    put(5'h17, 8'h00, 8'h00, 8'h00);
    q.bit_sel = 3'h1;
    go();
    chk("pin read", 16'(rsp.acc), 16'h005A);
    chk("pin bit", 16'(rsp.flags.c), 16'h0001);
    put(5'h19, 8'h00, 8'h00, 8'h00);
    q.bit_sel = 3'h3;
    go();
    chk("bit write", {7'h00, rsp.port_we, rsp.port_wr}, 16'h0134);
    @(negedge mclk);
    chk("latch", 16'(port_latch), 16'h0034);
    put(5'h0E, 8'h00, 8'h00, 8'h00);
    q.bit_sel = 3'h2;
    q.bit_val = 1'b1;
    go();
    chk("bit branch", 16'(rsp.taken), 16'h0001);
    @(negedge mclk);
    chk("bit cleared", 16'(port_latch), 16'h0030);
  endtask : t_port

  initial begin
    sys_rst      = 1'b1;
    start        = 1'b0;
    q            = '0;
    req          = '0;
    flags_in     = 3'h0;
    port_pins    = 8'h5A;
    error_cnt    = 0;
    total_checks = 0;
    n            = 0;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    t_timing();
    t_branch();
    t_arith();
    t_muldiv();
    t_port();
    end_of_test();
  end
endmodule : mcuex_core_test
